// [src/dmac_cmd_handler.sv]
// Debug memory access command handler: decodes host commands and moves bytes.
`include "dmac_params.svh"

// Functional notes
// [R1] Option byte at program address zero, cached.
// [R2] Host sends command, address, count, then data.
// [R3] Command 0BH returns program memory bytes.
// [R4] Count zero means 65536 bytes.
// [R5] Program read gives FFH if blocked.
// [R6] Command 0CH writes data memory unless blocked.
// [R7] Command 0DH reads data; FFH outside debug.
// [R8] Command 0AH writes program memory unless blocked.
// [R9] Address increments, count decrements, then idle.
module dmac_cmd_handler (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       debug_mode,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_valid,
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	input  wire logic       tx_ready,
	output logic            mem_prog,
	output logic            mem_rd,
	output logic            mem_wr,
	output logic [15:0]     mem_addr,
	output logic [7:0]      mem_wdata,
	input  wire logic [7:0] mem_rdata,
	input  wire logic       mem_rvalid,
	output logic            read_protect_option,
	output logic            write_protect_option,
	output logic            busy
);
	import dmac_pkg::*;

	// ****************************************************************
	// Command sequencing
	// ****************************************************************
	dmac_state_t state;
	logic [7:0]  cmd;
	logic [15:0] addr;
	logic [16:0] remain;
	logic        opt_loaded;
	logic        opt_pending;
	logic        is_prog;
	logic        blocked;
	logic        known_cmd;
	logic        rd_pending;

	assign is_prog   = (cmd == `DMAC_CMD_WR_PROG) || (cmd == `DMAC_CMD_RD_PROG);
	assign known_cmd = (rx_data >= `DMAC_CMD_WR_PROG) && (rx_data <= `DMAC_CMD_RD_DATA);
	// Data reads ignore read protection so the host can still inspect RAM.
	assign blocked   = !debug_mode || (is_prog && read_protect_option) ||
	                   (cmd == `DMAC_CMD_WR_DATA && read_protect_option); // R5 R6 R7 R8

	always_ff @(posedge clk) begin
		if (reset) begin
			state  <= DMAC_ST_CMD;
			cmd    <= 8'h00;
			addr   <= 16'h0000;
			remain <= 17'h00000;
		end else begin
			unique case (state)
				DMAC_ST_CMD: begin
					if (rx_valid && known_cmd && opt_loaded) begin // R2
						cmd   <= rx_data;
						state <= DMAC_ST_AHI;
					end
				end
				DMAC_ST_AHI: begin
					if (rx_valid) begin
						addr[15:8] <= rx_data;
						state      <= DMAC_ST_ALO;
					end
				end
				DMAC_ST_ALO: begin
					if (rx_valid) begin
						addr[7:0] <= rx_data;
						state     <= DMAC_ST_CHI;
					end
				end
				DMAC_ST_CHI: begin
					if (rx_valid) begin
						remain <= {1'b0, rx_data, 8'h00};
						state  <= DMAC_ST_CLO;
					end
				end
				DMAC_ST_CLO: begin
					if (rx_valid) begin
						if (remain[15:8] == 8'h00 && rx_data == 8'h00) begin
							remain <= 17'h10000; // R4
						end else begin
							remain <= {1'b0, remain[15:8], rx_data};
						end
						if (cmd == `DMAC_CMD_WR_PROG || cmd == `DMAC_CMD_WR_DATA) begin
							state <= DMAC_ST_WDATA;
						end else begin
							state <= DMAC_ST_RREQ;
						end
					end
				end
				DMAC_ST_WDATA: begin
					if (rx_valid) begin
						addr   <= addr + 16'h0001; // R9
						remain <= remain - 17'h00001;
						if (remain == 17'h00001) begin
							state <= DMAC_ST_CMD;
						end
					end
				end
				DMAC_ST_RREQ: begin
					if (blocked || mem_rvalid) begin
						state <= DMAC_ST_RSEND;
					end
				end
				DMAC_ST_RSEND: begin
					if (tx_valid && tx_ready) begin
						addr   <= addr + 16'h0001; // R9
						remain <= remain - 17'h00001;
						state  <= (remain == 17'h00001) ? DMAC_ST_CMD : DMAC_ST_RREQ;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Option byte capture
	// ****************************************************************
	// The option byte is fetched once after reset; commands wait for it.
	always_ff @(posedge clk) begin
		if (reset) begin
			opt_loaded           <= 1'b0;
			opt_pending          <= 1'b0;
			read_protect_option  <= 1'b1;
			write_protect_option <= 1'b0;
		end else if (!opt_loaded) begin
			opt_pending <= 1'b1;
			if (opt_pending && mem_rvalid) begin
				read_protect_option  <= mem_rdata[`DMAC_RP_BIT]; // R1
				write_protect_option <= mem_rdata[`DMAC_WP_BIT]; // R1
				opt_loaded           <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Memory and reply outputs
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_prog  <= 1'b1;
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_addr  <= `DMAC_OPT_ADDR;
			mem_wdata <= 8'h00;
			rd_pending <= 1'b0;
		end else begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			// Memory latency may exceed one cycle, so one read stays outstanding at a time.
			if (mem_rvalid) begin
				rd_pending <= 1'b0;
			end
			if (!opt_loaded) begin
				mem_prog <= 1'b1;
				mem_addr <= `DMAC_OPT_ADDR;
				mem_rd   <= !opt_pending;
			end else if (state == DMAC_ST_WDATA && rx_valid && !blocked) begin
				mem_prog  <= is_prog; // R6 R8
				mem_addr  <= addr;
				mem_wdata <= rx_data;
				mem_wr    <= 1'b1;
			end else if (state == DMAC_ST_RREQ && !blocked && !rd_pending) begin
				mem_prog   <= is_prog; // R3 R7
				mem_addr   <= addr;
				mem_rd     <= 1'b1;
				rd_pending <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else if (state == DMAC_ST_RREQ && (blocked || mem_rvalid)) begin
			tx_valid <= 1'b1;
			tx_data  <= blocked ? `DMAC_BLANK_BYTE : mem_rdata; // R5 R7
		end else if (tx_valid && tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			busy <= 1'b1;
		end else begin
			busy <= !(state == DMAC_ST_CMD && opt_loaded);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_blank_read;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_RREQ && blocked) |=> (tx_valid && tx_data == `DMAC_BLANK_BYTE);
	endproperty
	a_blank_read: assert property (p_blank_read) else $error("Blocked read not FFH."); // R5

	property p_no_blocked_write;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_WDATA && rx_valid && blocked) |=> !mem_wr;
	endproperty
	a_no_blocked_write: assert property (p_no_blocked_write) else $error("Blocked write."); // R8

	property p_data_rd_unprotected;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_RREQ && cmd == `DMAC_CMD_RD_DATA && debug_mode && !rd_pending)
		|=> mem_rd && !mem_prog;
	endproperty
	a_data_rd_unprotected: assert property (p_data_rd_unprotected) else $error("Data read lost."); // R7

	property p_zero_count;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_CLO && rx_valid && rx_data == 8'h00 && remain[15:8] == 8'h00)
		|=> remain == 17'h10000;
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("Zero count not 65536."); // R4

	property p_addr_step;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_WDATA && rx_valid) |=> addr == $past(addr) + 16'h0001;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("Address did not step."); // R9

	property p_write_data;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_WDATA && rx_valid && !blocked && cmd == `DMAC_CMD_WR_DATA)
		|=> mem_wr && !mem_prog && mem_wdata == $past(rx_data);
	endproperty
	a_write_data: assert property (p_write_data) else $error("Data write wrong."); // R6

	sequence s_last_send;
		state == DMAC_ST_RSEND && tx_valid && tx_ready && remain == 17'h00001;
	endsequence
	property p_end_idle;
		@(posedge clk) disable iff (reset)
		s_last_send |=> state == DMAC_ST_CMD;
	endproperty
	a_end_idle: assert property (p_end_idle) else $error("Did not return idle."); // R9

	property p_prog_read;
		@(posedge clk) disable iff (reset)
		(state == DMAC_ST_RREQ && mem_rvalid && !blocked && cmd == `DMAC_CMD_RD_PROG)
		|=> tx_valid && tx_data == $past(mem_rdata);
	endproperty
	a_prog_read: assert property (p_prog_read) else $error("Program byte not returned."); // R3

	property p_option_latch;
		@(posedge clk) disable iff (reset)
		(!opt_loaded && opt_pending && mem_rvalid)
		|=> read_protect_option == $past(mem_rdata[`DMAC_RP_BIT]);
	endproperty
	a_option_latch: assert property (p_option_latch) else $error("Option not latched."); // R1
endmodule : dmac_cmd_handler

// [pkg/dmac_params.svh]
// Constants for the debug memory access command handler.
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
`define DMAC_CMD_WR_PROG   8'h0A
`define DMAC_CMD_RD_PROG   8'h0B
`define DMAC_CMD_WR_DATA   8'h0C
`define DMAC_CMD_RD_DATA   8'h0D
`define DMAC_BLANK_BYTE    8'hFF
`define DMAC_OPT_ADDR      16'h0000
`define DMAC_RP_BIT        2
`define DMAC_WP_BIT        0
`endif

// [pkg/dmac_pkg.sv]
// Types for the debug memory access command handler.
package dmac_pkg;
	typedef enum logic [2:0] {
		DMAC_ST_CMD   = 3'b000,
		DMAC_ST_AHI   = 3'b001,
		DMAC_ST_ALO   = 3'b010,
		DMAC_ST_CHI   = 3'b011,
		DMAC_ST_CLO   = 3'b100,
		DMAC_ST_WDATA = 3'b101,
		DMAC_ST_RREQ  = 3'b110,
		DMAC_ST_RSEND = 3'b111
	} dmac_state_t;
endpackage : dmac_pkg

// [bench/dmac_mem_model.sv]
// Program and data memory model answering the command handler's strobes.
module dmac_mem_model (
	input  wire logic        clk,
	input  wire logic        mem_prog,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic [7:0]       mem_rdata,
	output logic             mem_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] prog [256];
	logic [7:0] dat  [256];
	logic [7:0] a;
	logic       p;
	logic       slow;
	logic [1:0] cnt;
	// Arrays survive reset, so a written option byte is seen at the next load.
	initial begin
		for (int i = 0; i < 256; i++) begin
			prog[i] = 8'(i) ^ 8'h5A;
			dat[i]  = 8'(i) + 8'h30;
		end
		prog[0] = 8'h01;
		{mem_rdata, mem_rvalid, cnt, slow} = '0;
	end
	// Latency alternates between two and four cycles; idle data keeps toggling.
	always @(posedge clk) begin
		mem_rvalid <= 1'b0;
		mem_rdata  <= ~mem_rdata;
		if (mem_wr && mem_prog)
			prog[mem_addr[7:0]] <= mem_wdata;
		if (mem_wr && !mem_prog)
			dat[mem_addr[7:0]] <= mem_wdata;
		if (mem_rd) begin
			a    <= mem_addr[7:0];
			p    <= mem_prog;
			cnt  <= slow ? 2'h3 : 2'h1;
			slow <= ~slow;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= p ? prog[a] : dat[a];
			end
		end
	end
endmodule : dmac_mem_model

// [bench/debug_memory_access_commands_tb.sv]
// Self-checking testbench of the debug memory access command handler.
`include "dmac_params.svh"
module debug_memory_access_commands_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset, debug_mode, rx_valid, tx_ready, tx_valid;
	logic mem_prog, mem_rd, mem_wr, mem_rvalid, rp, wp, busy;
	logic [7:0]  rx_data, tx_data, mem_wdata, mem_rdata;
	logic [15:0] mem_addr;
	int          err_total, total_checks;
	dmac_cmd_handler uut (.clk(clk), .reset(reset), .debug_mode(debug_mode),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .mem_prog(mem_prog), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .read_protect_option(rp), .write_protect_option(wp),
		.busy(busy));
	dmac_mem_model mem (.clk(clk), .mem_prog(mem_prog), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task send(input logic [7:0] b);
		@(posedge clk) rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk) rx_valid <= 1'b0;
	endtask : send
	task hdr(input logic [7:0] c, input logic [15:0] ad, input logic [15:0] n);
		send(c);
		send(ad[15:8]);
		send(ad[7:0]);
		send(n[15:8]);
		send(n[7:0]);
	endtask : hdr
	// The reply is checked once when tx_valid is seen, then held unaccepted for a cycle before tx_ready.
	task get(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (tx_valid !== 1'b1 && n < 200);
		chk({7'h00, tx_valid}, 8'h01);
		chk(tx_data, e);
		@(posedge clk) tx_ready <= 1'b1;
		@(posedge clk) tx_ready <= 1'b0;
	endtask : get
	task rst();
		int n;
		@(posedge clk) reset <= 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (busy !== 1'b0 && n < 50);
		chk({7'h00, busy}, 8'h00);
	endtask : rst
	task close_out();
		$display("mismatches %0d comparisons %0d", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	initial begin
		{reset, debug_mode, rx_valid, rx_data, tx_ready} = 12'hC00;
		{err_total, total_checks} = '0;
		rst();
		chk({7'h00, rp}, 8'h00);
		chk({7'h00, wp}, 8'h01);
		hdr(`DMAC_CMD_RD_PROG, 16'h0010, 16'h0003);
		for (int i = 0; i < 3; i++) get((8'h10 + 8'(i)) ^ 8'h5A);
		hdr(`DMAC_CMD_WR_DATA, 16'h0020, 16'h0002);
		send(8'hA5);
		send(8'h3C);
		hdr(`DMAC_CMD_RD_DATA, 16'h001F, 16'h0003);
		get(8'h4F);
		get(8'hA5);
		get(8'h3C);
		@(posedge clk) debug_mode <= 1'b0;
		hdr(`DMAC_CMD_RD_PROG, 16'h0011, 16'h0001);
		get(`DMAC_BLANK_BYTE);
		hdr(`DMAC_CMD_RD_DATA, 16'h0020, 16'h0001);
		get(`DMAC_BLANK_BYTE);
		hdr(`DMAC_CMD_WR_DATA, 16'h0020, 16'h0001);
		send(8'h00);
		@(posedge clk) debug_mode <= 1'b1;
		hdr(`DMAC_CMD_RD_DATA, 16'h0020, 16'h0001);
		get(8'hA5);
		hdr(`DMAC_CMD_WR_PROG, 16'h0000, 16'h0001);
		send(8'h04);
		rst();
		chk({7'h00, rp}, 8'h01);
		chk({7'h00, wp}, 8'h00);
		hdr(`DMAC_CMD_RD_PROG, 16'h0010, 16'h0001);
		get(`DMAC_BLANK_BYTE);
		hdr(`DMAC_CMD_WR_DATA, 16'h0021, 16'h0001);
		send(8'h00);
		hdr(`DMAC_CMD_RD_DATA, 16'h0021, 16'h0001);
		get(8'h3C);
		hdr(`DMAC_CMD_WR_PROG, 16'h0000, 16'h0001);
		send(8'h01);
		rst();
		chk({7'h00, rp}, 8'h01);
		// A zero count must keep streaming for 150 bytes, past a reading of zero or one but short of 256.
		hdr(`DMAC_CMD_RD_DATA, 16'h0040, 16'h0000);
		for (int i = 0; i < 150; i++) get(8'h70 + 8'(i));
		chk({7'h00, busy}, 8'h01);
		rst();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule : debug_memory_access_commands_tb
